// ---- hw/sca_alu.sv ----
// execution unit: stack top cells, carry, exponent ops and decode
//
// Operation
// RULE_01 - word store: second cell to resource register
// RULE_02 - software avoids config stores during bus traffic
// RULE_03 - bit store sets or clears addressed bit
// RULE_04 - subtract top from second, carry is borrow
// RULE_05 - subtract with borrow uses current carry
// RULE_06 - exponent difference: e1 minus e2 plus bias-1
// RULE_07 - result sign is xor of signs
// RULE_08 - bias 127 or 1023 by width select
// RULE_09 - mantissas out with hidden bit set
// RULE_10 - overflow when exponent reaches field maximum
// RULE_11 - underflow when exponent zero or negative
// RULE_12 - exception keeps low exponent bits
// RULE_13 - zero byte test sets carry
// RULE_14 - exponent range test, clears rounding bits
// RULE_15 - swap top two cells
// RULE_16 - xor top two cells
// RULE_17 - literal push opcodes 0x20..0x2F
// RULE_18 - global register push/pop opcodes
// RULE_19 - exceptions are one-cycle pulses
`timescale 1ns/1ns
`include "sca_cfg.svh"
module sca_alu #(
  parameter int AW = `SCA_RES_ADDR_W
) (
  input  wire logic          clk_sys,            // processor clock
  input  wire logic          rst_n,              // async reset, low
  input  wire logic          op_valid,           // opcode valid this cycle
  input  wire logic [7:0]    opcode,             // instruction byte
  input  wire logic          float_width_select, // 1 = double precision
  input  wire logic [31:0]   gr_rdata,           // selected global register value
  input  wire logic [AW-1:0] res_rd_addr,        // resource register read address
  output logic      [31:0]   tos,                // top cell
  output logic      [31:0]   nos,                // second cell
  output logic      [31:0]   third,              // third cell (mantissa n3)
  output logic               carry,              // carry flag
  output logic      [2:0]    rounding_extension_bits, // rounding extension
  output logic               exc_overflow,       // exponent overflow pulse
  output logic               exc_underflow,      // exponent underflow pulse
  output logic               exc_exponent,       // exponent range pulse
  output logic      [3:0]    global_regs_idx,    // global register index
  output logic               global_regs_we,     // global register write pulse
  output logic      [31:0]   global_regs_wdata,  // global register write data
  output logic      [31:0]   res_rd_data         // resource register read data
);
  import sca_pkg::*;

  sca_dec_if dbus ();
  sca_decoder u_dec (
    .opcode (opcode),
    .dec    (dbus.dec)
  );

  logic [31:0] tos_reg, tos_next;
  logic [31:0] nos_reg, nos_next;
  logic [31:0] thd_reg, thd_next;
  logic        cy_reg, cy_next;
  logic [2:0]  rx_reg, rx_next;
  logic        ov_reg, ov_next;
  logic        un_reg, un_next;
  logic        ex_reg, ex_next;
  logic [3:0]  gi_reg;
  logic        gw_reg, gw_next;
  logic [31:0] gd_reg;
  logic [31:0] rd_reg;
  logic [31:0] res_rdata;
  logic        zbyte_q;

  wire run = op_valid;
  wire dp  = float_width_select;

  // resource bank: store consumes address cell, data cell stays
  wire st_word = run && dbus.kind == SCA_K_STO;
  wire st_bit  = run && dbus.kind == SCA_K_STOBIT;
  sca_resreg #(.AW(AW)) u_res (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_word (st_word),
    .wr_bit  (st_bit),
    .addr    (tos_reg),
    .data    (nos_reg),
    .rd_addr (res_rd_addr),
    .rd_data (res_rdata)
  );

  // subtract family, 33-bit so the top bit is the borrow
  wire        cin     = (dbus.kind == SCA_K_SUBB) ? cy_reg : 1'b0; // RULE_05
  wire [32:0] diff    = {1'b0, nos_reg} - {1'b0, tos_reg} - {32'h0000_0000, cin}; // RULE_04

  // exponent fields at the selected precision
  wire [11:0] e1      = dp ? {1'b0, nos_reg[30:`SCA_DP_EXP_LSB]}
                           : {4'h0, nos_reg[30:`SCA_SP_EXP_LSB]};
  wire [11:0] e2      = dp ? {1'b0, tos_reg[30:`SCA_DP_EXP_LSB]}
                           : {4'h0, tos_reg[30:`SCA_SP_EXP_LSB]};
  wire [11:0] bias    = dp ? `SCA_BIAS_DP : `SCA_BIAS_SP; // RULE_08
  wire [11:0] emax    = dp ? `SCA_EMAX_DP : `SCA_EMAX_SP;
  // signed 13-bit result keeps negatives visible for underflow
  wire signed [12:0] eres = $signed({1'b0, e1}) - $signed({1'b0, e2})
                          + $signed({1'b0, bias}) - 13'sd1; // RULE_06
  wire        e_ovf   = eres >= $signed({1'b0, emax}); // RULE_10
  wire        e_unf   = eres <= 13'sd0; // RULE_11
  wire        sgn     = nos_reg[`SCA_SIGN_BIT] ^ tos_reg[`SCA_SIGN_BIT]; // RULE_07
  wire [31:0] expmask = dp ? `SCA_DP_EXPMASK : `SCA_SP_EXPMASK;
  wire [31:0] hidden  = dp ? `SCA_DP_HIDDEN : `SCA_SP_HIDDEN;
  wire [31:0] keepm   = ~(expmask | 32'h8000_0000);
  wire [31:0] mant1   = (nos_reg & keepm) | hidden; // RULE_09
  wire [31:0] mant2   = (tos_reg & keepm) | hidden; // RULE_09
  // low exponent bits are kept on exception by plain truncation
  wire [31:0] efield  = dp ? {1'b0, eres[10:0], 20'h00000}
                           : {1'b0, eres[7:0], 23'h000000}; // RULE_12
  wire [31:0] n5      = {sgn, 31'h0000_0000} | efield;

  // range test: all zeros or all ones in either exponent
  wire        e1_bad  = (e1 == 12'h000) || (e1 == emax);
  wire        e2_bad  = (e2 == 12'h000) || (e2 == emax);
  wire        rng_bad = e1_bad || e2_bad; // RULE_14

  wire        zbyte   = (tos_reg[31:24] == 8'h00) || (tos_reg[23:16] == 8'h00)
                     || (tos_reg[15:8] == 8'h00) || (tos_reg[7:0] == 8'h00); // RULE_13

  always_comb begin
    tos_next = tos_reg;
    nos_next = nos_reg;
    thd_next = thd_reg;
    cy_next  = cy_reg;
    rx_next  = rx_reg;
    ov_next  = 1'b0;
    un_next  = 1'b0;
    ex_next  = 1'b0;
    gw_next  = 1'b0;
    if (run) begin
      case (dbus.kind)
        SCA_K_STO, SCA_K_STOBIT: begin
          tos_next = nos_reg; // RULE_01
          nos_next = thd_reg;
        end
        SCA_K_XCG: begin
          tos_next = nos_reg; // RULE_15
          nos_next = tos_reg;
        end
        SCA_K_XOR: begin
          tos_next = nos_reg ^ tos_reg; // RULE_16
          nos_next = thd_reg;
        end
        SCA_K_SUB, SCA_K_SUBB: begin
          tos_next = diff[31:0]; // RULE_04
          nos_next = thd_reg;
          cy_next  = diff[32]; // RULE_05
        end
        SCA_K_SUBEXP: begin
          tos_next = n5;
          nos_next = mant2;
          thd_next = mant1;
          ov_next  = e_ovf; // RULE_19
          un_next  = e_unf; // RULE_19
        end
        SCA_K_TESTEXP: begin
          rx_next  = 3'b000; // RULE_14
          cy_next  = rng_bad;
          ex_next  = rng_bad; // RULE_19
        end
        SCA_K_TESTB: cy_next = zbyte; // RULE_13
        SCA_K_LIT, SCA_K_GPUSH: begin
          thd_next = nos_reg;
          nos_next = tos_reg;
          tos_next = (dbus.kind == SCA_K_LIT) ? dbus.literal : gr_rdata; // RULE_17
        end
        SCA_K_GPOP: begin
          gw_next  = 1'b1; // RULE_18
          tos_next = nos_reg;
          nos_next = thd_reg;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tos_reg <= 32'h0000_0000;
      nos_reg <= 32'h0000_0000;
      thd_reg <= 32'h0000_0000;
      cy_reg  <= 1'b0;
      rx_reg  <= 3'b000;
      ov_reg  <= 1'b0;
      un_reg  <= 1'b0;
      ex_reg  <= 1'b0;
      gw_reg  <= 1'b0;
      gi_reg  <= 4'h0;
      gd_reg  <= 32'h0000_0000;
      rd_reg  <= 32'h0000_0000;
    end else begin
      tos_reg <= tos_next;
      nos_reg <= nos_next;
      thd_reg <= thd_next;
      cy_reg  <= cy_next;
      rx_reg  <= rx_next;
      ov_reg  <= ov_next;
      un_reg  <= un_next;
      ex_reg  <= ex_next;
      gw_reg  <= gw_next;
      gi_reg  <= dbus.greg;
      gd_reg  <= tos_reg;
      rd_reg  <= res_rdata;
    end
  end

  assign tos                     = tos_reg;
  assign nos                     = nos_reg;
  assign third                   = thd_reg;
  assign carry                   = cy_reg;
  assign rounding_extension_bits = rx_reg;
  assign exc_overflow            = ov_reg;
  assign exc_underflow           = un_reg;
  assign exc_exponent            = ex_reg;
  assign global_regs_idx         = gi_reg;
  assign global_regs_we          = gw_reg;
  assign global_regs_wdata       = gd_reg;
  assign res_rd_data             = rd_reg;

  // checks
  chk_sub_result: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    run && dbus.kind == SCA_K_SUB |=> tos_reg == $past(nos_reg) - $past(tos_reg)
      && cy_reg == ($past(tos_reg) > $past(nos_reg)))
    else $error("sub result or borrow wrong");
  chk_subb_borrow: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    run && dbus.kind == SCA_K_SUBB |=>
      tos_reg == $past(nos_reg) - $past(tos_reg) - {31'h0, $past(cy_reg)})
    else $error("subtract with borrow wrong");
  chk_xcg_swap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    run && dbus.kind == SCA_K_XCG |=> tos_reg == $past(nos_reg) && nos_reg == $past(tos_reg))
    else $error("swap failed");
  chk_xor_result: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_16
    run && dbus.kind == SCA_K_XOR |=> tos_reg == ($past(nos_reg) ^ $past(tos_reg)))
    else $error("xor result wrong");
  chk_testb_carry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_13
    run && dbus.kind == SCA_K_TESTB |=> cy_reg == zbyte_q && tos_reg == $past(tos_reg))
    else $error("zero byte test wrong");
  chk_exc_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_19
    exc_overflow && !$past(run && dbus.kind == SCA_K_SUBEXP) |-> 1'b0)
    else $error("overflow without subexp");
  chk_sign_xor: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    run && dbus.kind == SCA_K_SUBEXP |=>
      tos_reg[31] == ($past(nos_reg[31]) ^ $past(tos_reg[31])))
    else $error("result sign wrong");
  chk_exp_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    run && dbus.kind == SCA_K_SUBEXP && !dp |=>
      tos_reg[30:23] == 8'($past(nos_reg[30:23]) - $past(tos_reg[30:23]) + 8'd126))
    else $error("single exponent difference wrong");
  chk_testexp_rx: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_14
    run && dbus.kind == SCA_K_TESTEXP |=> rx_reg == 3'b000 && cy_reg == exc_exponent)
    else $error("exponent range test wrong");
  chk_lit_push: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_17
    run && opcode == `SCA_OP_LIT_HI |=> tos_reg == 32'hFFFF_FFFF)
    else $error("literal -1 push wrong");
  chk_lit_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_17
    run && opcode == `SCA_OP_LIT_LO |=> tos_reg == 32'h0000_0000)
    else $error("literal 0 push wrong");
  chk_sub_stack: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    run && dbus.kind == SCA_K_SUB |=> nos_reg == $past(thd_reg))
    else $error("sub did not drop the second cell");
  chk_subb_carry: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    run && dbus.kind == SCA_K_SUBB |=> cy_reg == ({1'b0, $past(nos_reg)}
      < {1'b0, $past(tos_reg)} + {32'h0000_0000, $past(cy_reg)}))
    else $error("subtract with borrow carry wrong");
  chk_exp_double: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    run && dbus.kind == SCA_K_SUBEXP && dp |=>
      tos_reg[30:20] == 11'($past(nos_reg[30:20]) - $past(tos_reg[30:20]) + 11'd1022))
    else $error("double exponent difference wrong");
  // flag checks widen both sides so a wrapped exponent cannot hide
  chk_ovf_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    run && dbus.kind == SCA_K_SUBEXP && !dp |=>
      exc_overflow == ({2'b00, $past(nos_reg[30:23])} + 10'd126
        >= {2'b00, $past(tos_reg[30:23])} + 10'd255))
    else $error("single overflow flag wrong");
  chk_unf_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    run && dbus.kind == SCA_K_SUBEXP && !dp |=>
      exc_underflow == ({2'b00, $past(nos_reg[30:23])} + 10'd126
        <= {2'b00, $past(tos_reg[30:23])}))
    else $error("single underflow flag wrong");
  chk_ovf_double: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    run && dbus.kind == SCA_K_SUBEXP && dp |=>
      exc_overflow == ({1'b0, $past(nos_reg[30:20])} + 12'd1022
        >= {1'b0, $past(tos_reg[30:20])} + 12'd2047))
    else $error("double overflow flag wrong");
  chk_unf_double: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_11
    run && dbus.kind == SCA_K_SUBEXP && dp |=>
      exc_underflow == ({1'b0, $past(nos_reg[30:20])} + 12'd1022
        <= {1'b0, $past(tos_reg[30:20])}))
    else $error("double underflow flag wrong");
  chk_mant_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    run && dbus.kind == SCA_K_SUBEXP && !dp |=>
      nos_reg == ({9'h000, $past(tos_reg[22:0])} | `SCA_SP_HIDDEN)
      && thd_reg == ({9'h000, $past(nos_reg[22:0])} | `SCA_SP_HIDDEN))
    else $error("single mantissa output wrong");
  chk_mant_double: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_09
    run && dbus.kind == SCA_K_SUBEXP && dp |=>
      nos_reg == ({12'h000, $past(tos_reg[19:0])} | `SCA_DP_HIDDEN)
      && thd_reg == ({12'h000, $past(nos_reg[19:0])} | `SCA_DP_HIDDEN))
    else $error("double mantissa output wrong");
  chk_unf_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_19
    exc_underflow |-> $past(run && dbus.kind == SCA_K_SUBEXP))
    else $error("underflow without subexp");
  chk_exc_source: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_19
    exc_exponent |-> $past(run && dbus.kind == SCA_K_TESTEXP))
    else $error("exponent exception without testexp");
  chk_range_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_14
    run && dbus.kind == SCA_K_TESTEXP && !dp |=>
      cy_reg == ($past(nos_reg[30:23]) inside {8'h00, 8'hFF}
        || $past(tos_reg[30:23]) inside {8'h00, 8'hFF}))
    else $error("single range test carry wrong");
  chk_gpop_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_18
    run && dbus.kind == SCA_K_GPOP |=> global_regs_we && global_regs_wdata == $past(tos_reg)
      && global_regs_idx == $past(opcode[3:0]))
    else $error("global pop write wrong");
  chk_gwe_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_18
    global_regs_we |-> $past(run && dbus.kind == SCA_K_GPOP))
    else $error("global write without pop");
  chk_gpush_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_18
    run && dbus.kind == SCA_K_GPUSH |=> tos_reg == $past(gr_rdata) && nos_reg == $past(tos_reg))
    else $error("global push wrong");
  chk_sto_stack: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    run && dbus.kind == SCA_K_STO |=> tos_reg == $past(nos_reg) && nos_reg == $past(thd_reg))
    else $error("store did not keep the data cell");
  chk_stobit_keep: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    run && dbus.kind == SCA_K_STOBIT |=> tos_reg == $past(nos_reg) && nos_reg == $past(thd_reg))
    else $error("bit store did not keep the data cell");
  chk_xcg_keep: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    run && dbus.kind == SCA_K_XCG |=> cy_reg == $past(cy_reg) && thd_reg == $past(thd_reg))
    else $error("swap disturbed carry or third cell");
  chk_xor_stack: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_16
    run && dbus.kind == SCA_K_XOR |=> nos_reg == $past(thd_reg))
    else $error("xor did not drop the second cell");

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      zbyte_q <= 1'b0;
    else
      zbyte_q <= zbyte;
  end
endmodule

// ---- hw/sca_cfg.svh ----
// constants for the stack cpu alu op subset
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH
`define SCA_OP_STO     8'hB0
`define SCA_OP_STOBIT  8'hB1
`define SCA_OP_XCG     8'hB2
`define SCA_OP_XOR     8'hC3
`define SCA_OP_SUB     8'hC8
`define SCA_OP_SUBB    8'hCA
`define SCA_OP_SUBEXP  8'hD3
`define SCA_OP_TESTEXP 8'hD4
`define SCA_OP_TESTB   8'hD9
`define SCA_OP_LIT_LO  8'h20
`define SCA_OP_LIT_HI  8'h2F
`define SCA_OP_LIT_NEG 8'h29
`define SCA_OP_GPUSH   8'h70
`define SCA_OP_GPOP    8'h50
`define SCA_OP_GMASK   8'hF0
`define SCA_BIAS_SP    12'h07F
`define SCA_BIAS_DP    12'h3FF
`define SCA_EMAX_SP    12'h0FF
`define SCA_EMAX_DP    12'h7FF
`define SCA_SP_EXP_LSB 23
`define SCA_DP_EXP_LSB 20
`define SCA_SIGN_BIT   31
`define SCA_SP_HIDDEN  32'h0080_0000
`define SCA_DP_HIDDEN  32'h0010_0000
`define SCA_SP_EXPMASK 32'h7F80_0000
`define SCA_DP_EXPMASK 32'h7FF0_0000
`define SCA_RES_ADDR_W 8
`define SCA_RES_COUNT  256
`endif

// ---- hw/sca_dec_if.sv ----
// decoded instruction bundle between decoder and execution unit
`timescale 1ns/1ns
interface sca_dec_if;
  import sca_pkg::*;
  sca_kind_e   kind;
  logic [31:0] literal;
  logic [3:0]  greg;
  modport dec (output kind, output literal, output greg);
  modport exe (input kind, input literal, input greg);
endinterface

// ---- hw/sca_decoder.sv ----
// opcode decoder for the alu op subset
`timescale 1ns/1ns
`include "sca_cfg.svh"
module sca_decoder (
  input wire logic [7:0] opcode,  // instruction byte
  sca_dec_if.dec         dec      // decoded bundle
);
  import sca_pkg::*;
  wire         is_lit  = (opcode >= `SCA_OP_LIT_LO) && (opcode <= `SCA_OP_LIT_HI);
  wire         lit_neg = (opcode >= `SCA_OP_LIT_NEG);
  wire [3:0]   lit_lo  = opcode[3:0];
  wire         is_gpsh = (opcode & `SCA_OP_GMASK) == `SCA_OP_GPUSH;
  wire         is_gpop = (opcode & `SCA_OP_GMASK) == `SCA_OP_GPOP;
  // negative literals 0x29..0x2F map to -7..-1: low nibble minus 16
  wire [31:0]  lit_val = lit_neg ? {28'hFFF_FFFF, lit_lo} : {28'h000_0000, lit_lo};
  assign dec.literal = lit_val; // RULE_17
  assign dec.greg    = lit_lo; // RULE_18
  always_comb begin
    if (is_lit)
      dec.kind = SCA_K_LIT; // RULE_17
    else if (is_gpsh)
      dec.kind = SCA_K_GPUSH; // RULE_18
    else if (is_gpop)
      dec.kind = SCA_K_GPOP; // RULE_18
    else begin
      case (opcode)
        `SCA_OP_STO:     dec.kind = SCA_K_STO;
        `SCA_OP_STOBIT:  dec.kind = SCA_K_STOBIT;
        `SCA_OP_XCG:     dec.kind = SCA_K_XCG;
        `SCA_OP_XOR:     dec.kind = SCA_K_XOR;
        `SCA_OP_SUB:     dec.kind = SCA_K_SUB;
        `SCA_OP_SUBB:    dec.kind = SCA_K_SUBB;
        `SCA_OP_SUBEXP:  dec.kind = SCA_K_SUBEXP;
        `SCA_OP_TESTEXP: dec.kind = SCA_K_TESTEXP;
        `SCA_OP_TESTB:   dec.kind = SCA_K_TESTB;
        default:         dec.kind = SCA_K_NONE;
      endcase
    end
  end
endmodule

// ---- hw/sca_pkg.sv ----
// types for the stack cpu alu op subset
package sca_pkg;
  typedef enum logic [3:0] {
    SCA_K_NONE   = 4'b0000,
    SCA_K_STO    = 4'b0001,
    SCA_K_STOBIT = 4'b0010,
    SCA_K_XCG    = 4'b0011,
    SCA_K_XOR    = 4'b0100,
    SCA_K_SUB    = 4'b0101,
    SCA_K_SUBB   = 4'b0110,
    SCA_K_SUBEXP = 4'b0111,
    SCA_K_TESTEXP= 4'b1000,
    SCA_K_TESTB  = 4'b1001,
    SCA_K_LIT    = 4'b1010,
    SCA_K_GPUSH  = 4'b1011,
    SCA_K_GPOP   = 4'b1100
  } sca_kind_e;
endpackage

// ---- hw/sca_resreg.sv ----
// on-chip resource register bank with word and bit store
`timescale 1ns/1ns
`include "sca_cfg.svh"
module sca_resreg #(
  parameter int AW = `SCA_RES_ADDR_W
) (
  input  wire logic          clk_sys,   // processor clock
  input  wire logic          rst_n,     // async reset, low
  input  wire logic          wr_word,   // word store strobe
  input  wire logic          wr_bit,    // bit store strobe
  input  wire logic [31:0]   addr,      // address cell
  input  wire logic [31:0]   data,      // data cell
  input  wire logic [AW-1:0] rd_addr,   // read address
  output logic      [31:0]   rd_data    // read data
);
  logic [31:0] mem_reg [2**AW];
  // bit address: upper bits pick the register, low five pick the bit
  wire [AW-1:0] bit_reg = addr[AW+4:5];
  wire [4:0]    bit_pos = addr[4:0];
  wire          bit_val = |data;
  assign rd_data = mem_reg[rd_addr];
  genvar gi;
  generate
    for (gi = 0; gi < 2**AW; gi++) begin : g_res
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          mem_reg[gi] <= 32'h0000_0000;
        else if (wr_word && addr[AW-1:0] == AW'(gi))
          mem_reg[gi] <= data; // RULE_01
        else if (wr_bit && bit_reg == AW'(gi))
          mem_reg[gi][bit_pos] <= bit_val; // RULE_03
      end
    end
  endgenerate
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the stack alu op subset
`timescale 1ns/1ns
`include "sca_cfg.svh"
module tb;
  logic        clk_sys;
  logic        rst_n;
  logic        op_valid;
  logic [7:0]  opcode;
  logic        float_width_select;
  logic [31:0] gr_rdata;
  logic [7:0]  res_rd_addr;
  logic [31:0] tos, nos, third, res_rd_data, global_regs_wdata;
  logic        carry, exc_overflow, exc_underflow, exc_exponent, global_regs_we;
  logic [2:0]  rounding_extension_bits;
  logic [3:0]  global_regs_idx;
  int          bad_count;
  int          n_compared;

  sca_alu #(.AW(8)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
    .float_width_select(float_width_select), .gr_rdata(gr_rdata),
    .res_rd_addr(res_rd_addr), .tos(tos), .nos(nos), .third(third), .carry(carry),
    .rounding_extension_bits(rounding_extension_bits), .exc_overflow(exc_overflow),
    .exc_underflow(exc_underflow), .exc_exponent(exc_exponent),
    .global_regs_idx(global_regs_idx), .global_regs_we(global_regs_we),
    .global_regs_wdata(global_regs_wdata), .res_rd_data(res_rd_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // op_valid is left high so ops can follow back to back; idle drops it
  task automatic op(input logic [7:0] code);
    op_valid = 1'b1;
    opcode = code;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic idle();
    op_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // any 32-bit value enters the stack through a global register push
  task automatic push(input logic [31:0] v);
    gr_rdata = v;
    op(`SCA_OP_GPUSH);
  endtask

  task automatic t_literals();
    logic [7:0] c;
    for (int i = 0; i < 16; i++) begin
      c = `SCA_OP_LIT_LO + 8'(i);
      op(c);
      chk(tos, (c < `SCA_OP_LIT_NEG) ? 32'(i) : 32'(i - 16));
    end
    idle();
  endtask

  task automatic t_globals();
    logic [31:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 32'hC0DE_0000 + 32'(i * 32'h111);
      gr_rdata = v;
      op(`SCA_OP_GPUSH + 8'(i));
      chk(tos, v);
      op(`SCA_OP_GPOP + 8'(i));
      chk({27'h0, global_regs_we, global_regs_idx}, {27'h0, 1'b1, 4'(i)});
      chk(global_regs_wdata, v);
    end
    idle();
    chk(32'(global_regs_we), 32'h0);
  endtask

  task automatic t_sub();
    logic [31:0] a[3];
    logic [31:0] b[3];
    logic [32:0] r;
    logic [32:0] q;
    a = '{32'h0000_0000, 32'h8000_0000, 32'h0000_0007};
    b = '{32'h0000_0001, 32'h7FFF_FFFF, 32'h0000_0007};
    for (int i = 0; i < 3; i++) begin
      push(32'h0BAD_CAFE);
      push(a[i]);
      push(b[i]);
      op(`SCA_OP_SUB);
      r = {1'b0, a[i]} - {1'b0, b[i]};
      chk(tos, r[31:0]);
      chk(nos, 32'h0BAD_CAFE);
      chk(32'(carry), 32'(r[32]));
      push(32'h0000_0003);
      op(`SCA_OP_SUBB);
      q = {1'b0, r[31:0]} - 33'h3 - 33'(r[32]);
      chk(tos, q[31:0]);
      chk(32'(carry), 32'(q[32]));
    end
    idle();
  endtask

  task automatic t_swap_xor();
    push(32'h1357_9BDF);
    push(32'h0F0F_00FF);
    push(32'hFFFF_0000);
    op(`SCA_OP_XCG);
    chk(tos, 32'h0F0F_00FF);
    chk(nos, 32'hFFFF_0000);
    chk(third, 32'h1357_9BDF);
    op(`SCA_OP_XOR);
    chk(tos, 32'hF0F0_00FF);
    chk(nos, 32'h1357_9BDF);
    idle();
  endtask

  task automatic t_testb();
    logic [31:0] v[5];
    logic        z;
    v = '{32'h1122_3344, 32'h0011_2233, 32'h1100_3344, 32'h1122_0044, 32'h1122_3300};
    for (int i = 0; i < 5; i++) begin
      push(v[i]);
      op(`SCA_OP_TESTB);
      z = (v[i][31:24] == 0) || (v[i][23:16] == 0) || (v[i][15:8] == 0) || (v[i][7:0] == 0);
      chk(tos, v[i]);
      chk(32'(carry), 32'(z));
    end
    idle();
  endtask

  task automatic t_store();
    logic [31:0] w;
    logic [31:0] d;
    logic [4:0]  bits[4];
    w = 32'hA5A5_5A4A;
    bits = '{5'd4, 5'd1, 5'd31, 5'd4};
    push(w);
    push(32'h0000_0013);
    // no bus traffic runs beside the bench, so no store can hit a busy group
    op(`SCA_OP_STO);
    chk(tos, w);
    res_rd_addr = 8'h13;
    idle();
    chk(res_rd_data, w);
    // alternate set and clear so a stuck bit shows either way
    for (int i = 0; i < 4; i++) begin
      d = (i % 2 == 0) ? 32'h8000_0000 : 32'h0;
      push(d);
      push({19'h0, 8'h13, bits[i]});
      op(`SCA_OP_STOBIT);
      chk(tos, d);
      w[bits[i]] = (d != 0);
      idle();
      chk(res_rd_data, w);
    end
    res_rd_addr = 8'h14;
    idle();
    chk(res_rd_data, 32'h0);
  endtask

  task automatic t_exp(input logic sub_op);
    logic [31:0] n1[7];
    logic [31:0] n2[7];
    logic        dp[7];
    logic [31:0] cm;
    logic [31:0] hid;
    logic        bad_e;
    int          e;
    int          sh;
    int          fm;
    n1 = '{32'h3F81_2345, 32'h4100_0001, 32'h4080_00F0, 32'h0080_0000,
           32'h0012_3456, 32'h3FF1_2345, 32'h7FE0_0001};
    n2 = '{32'h4002_3456, 32'h0080_0000, 32'h8080_0000, 32'h3F80_0000,
           32'h6400_0000, 32'hC000_0000, 32'h7FF0_0000};
    dp = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 7; i++) begin
      float_width_select = dp[i];
      push(n1[i]);
      push(n2[i]);
      op(sub_op ? `SCA_OP_SUBEXP : `SCA_OP_TESTEXP);
      sh = dp[i] ? 20 : 23;
      fm = dp[i] ? 32'h7FF : 32'hFF;
      e = int'((n1[i] >> sh) & fm) - int'((n2[i] >> sh) & fm) + (dp[i] ? 1023 : 127) - 1;
      hid = dp[i] ? `SCA_DP_HIDDEN : `SCA_SP_HIDDEN;
      cm = ~(32'h8000_0000 | (32'(fm) << sh));
      bad_e = (((n1[i] >> sh) & fm) inside {0, fm}) || (((n2[i] >> sh) & fm) inside {0, fm});
      if (sub_op) begin
        chk((tos >> sh) & 32'(fm), 32'(e) & 32'(fm));
        chk(32'(tos[31]), 32'(n1[i][31] ^ n2[i][31]));
        chk(nos, (n2[i] & cm) | hid);
        chk(third, (n1[i] & cm) | hid);
        chk({30'h0, exc_overflow, exc_underflow}, {30'h0, e >= fm, e <= 0});
      end else begin
        chk({29'h0, rounding_extension_bits}, 32'h0);
        chk({30'h0, carry, exc_exponent}, {30'h0, bad_e, bad_e});
      end
      idle();
      chk({29'h0, exc_overflow, exc_underflow, exc_exponent}, 32'h0);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // the whole sequence needs well under 500 cycles; allow ten times that
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    opcode = 8'h00;
    float_width_select = 1'b0;
    gr_rdata = 32'h0;
    res_rd_addr = 8'h00;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_literals();
    t_globals();
    t_sub();
    t_swap_xor();
    t_testb();
    t_store();
    t_exp(1'b1);
    t_exp(1'b0);
    finish_test();
  end
endmodule
